// ### verilog/host_bus_pkg.sv
`default_nettype none
package host_bus_pkg;
  typedef enum logic [2:0] {
    MODE_1,
    MODE_2,
    MODE_3,
    MODE_4,
    MODE_RESERVED
  } bus_mode_t;
  // Strap patterns: family, byte order, width variant
  localparam logic [2:0] STRAP_MODE4_LE = 3'h0;
  localparam logic [2:0] STRAP_MODE3_LE = 3'h1;
  localparam logic [2:0] STRAP_MODE4_BE = 3'h2;
  localparam logic [2:0] STRAP_RESERVED = 3'h3;
  localparam logic [2:0] STRAP_MODE2_LE = 3'h4;
  localparam logic [2:0] STRAP_MODE1_LE = 3'h5;
  localparam logic [2:0] STRAP_MODE2_BE = 3'h6;
  localparam logic [2:0] STRAP_MODE1_BE = 3'h7;
  // APB byte offsets
  localparam logic [7:0] DMA_MODE_OFS = 8'h00;
  localparam logic [7:0] DMA_CONTROL_OFS = 8'h04;
  localparam logic [7:0] CHIP_TEST_ZERO_OFS = 8'h08;
  localparam logic [7:0] PIN_CTRL_OFS = 8'h0C;
  localparam logic [7:0] CYCLE_CMD_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  // Field positions
  localparam int FC2_BIT = 5;
  localparam int FC1_BIT = 4;
  localparam int PROG_DATA_BIT = 3;
  localparam int PREVIEW_MODE_BIT = 6;
  localparam int CACHE_LINE_MODE_BIT = 0;
  localparam int TYPE1_BIT = 1;
  localparam int SNOOP_LSB = 0;
  localparam int SNOOP_PLAIN_BIT = 2;
  localparam int LOCAL_MEM_BIT = 3;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam int CMD_BURST_BIT = 2;
  localparam int CMD_FETCH_BIT = 3;
  // Reset values
  localparam logic [7:0] DMA_MODE_RST = 8'h00;
  localparam logic [7:0] DMA_CONTROL_RST = 8'h00;
  localparam logic [7:0] CHIP_TEST_ZERO_RST = 8'h00;
  localparam logic [7:0] PIN_CTRL_RST = 8'h00;
  // Cycle counts
  localparam logic [1:0] LINE_LAST_BEAT = 2'h3;
  localparam logic [2:0] SLAVE_DONE_CYC = 3'h2;
endpackage : host_bus_pkg
`default_nettype wire

// ### verilog/host_bus_ctrl.sv
// Operation
// - Decode three mode straps into four bus modes; pattern 011 is reserved.
// - Modes 3 and 4 master: hold each transfer until ready input asserts.
// - Modes 3 and 4 slave: release data drive when ready input seen.
// - Modes 1 and 2 master: termination/acknowledge input completes transfer.
// - Modes 1 and 2: assert slave acknowledge when slave cycle done inside.
// - Modes 1 and 2: slave cycle ends only on termination or error input.
// - Modes 3 and 4: assert ready output at end of each slave cycle that is not illegal.
// - Drive direction line as master, sample it as slave.
// - Function code 2 from mode bit 5; control bit 6 makes pin preview input.
// - Function code 1 from mode bit 4 with bit 6 clear; code 0 via bit 3.
// - Snoop outputs from register bits while master, or plain always.
// - Master status low while master, driven except in test mode.
// - Op-code fetch output announces next request is an instruction fetch.
// - Modes 1 and 4: burst request for four-longword line; mode 4 needs cache bit.
// - Transfer type 1 from test register bit 1 while master.
// - Master: burst inhibit blocks bursts in modes 2-4; mode 1 needs burst ack.
// - Selected as slave: burst ack deasserted mode 1, inhibit asserted else.
// - Local memory output high for local, low far; zero after reset.
// - Test-in low: AND tree to test-out, pull-ups on, all outputs tristated.
// - Test-out driven only while test-in low.
// - Assert bus error output on an illegal slave access in every mode.
// - Master retry on error with ack (modes 2-4) or error with halt (mode 1).
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module host_bus_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] bus_mode_select,
  input wire logic sync_cycle_termination_n,
  input wire logic halt_n,
  input wire logic chip_select_n,
  input wire logic slave_strobe_n,
  input wire logic slave_illegal,
  input wire logic conn_test_in_n,
  output logic conn_test_out,
  output logic conn_test_out_oe,
  output logic pullup_en,
  input wire logic bus_fault_n_in,
  output logic bus_fault_n_out,
  output logic bus_fault_n_oe,
  input wire logic line_burst_ack_n_in,
  output logic line_burst_ack_n_out,
  output logic line_burst_ack_n_oe,
  input wire logic read_write_in,
  output logic read_write_out,
  output logic read_write_oe,
  input wire logic func_code_2_or_preview_in,
  output logic func_code_2_or_preview_out,
  output logic func_code_2_or_preview_oe,
  output logic [1:0] func_code_low,
  output logic func_code_low_oe,
  output logic line_burst_request_n,
  output logic line_burst_request_oe,
  output logic [1:0] snoop_level,
  output logic snoop_oe,
  output logic master_status_n,
  output logic master_status_oe,
  output logic opcode_fetch_n,
  output logic opcode_fetch_oe,
  output logic local_memory_select,
  output logic local_memory_oe,
  output logic slave_cycle_done_n,
  output logic slave_cycle_done_oe,
  output logic slave_data_oe
);
  typedef enum logic [1:0] {M_IDLE, M_WAIT} mst_state_t;
  typedef enum logic [1:0] {S_IDLE, S_BUSY, S_ACK, S_HOLD} slv_state_t;

  function automatic host_bus_pkg::bus_mode_t decode_mode(
    input logic [2:0] strap);
    unique case (strap)
      host_bus_pkg::STRAP_MODE1_LE,
      host_bus_pkg::STRAP_MODE1_BE: decode_mode = host_bus_pkg::MODE_1;
      host_bus_pkg::STRAP_MODE2_LE,
      host_bus_pkg::STRAP_MODE2_BE: decode_mode = host_bus_pkg::MODE_2;
      host_bus_pkg::STRAP_MODE3_LE: decode_mode = host_bus_pkg::MODE_3;
      host_bus_pkg::STRAP_MODE4_LE,
      host_bus_pkg::STRAP_MODE4_BE: decode_mode = host_bus_pkg::MODE_4;
      default: decode_mode = host_bus_pkg::MODE_RESERVED;
    endcase
  endfunction : decode_mode

  function automatic logic is_68k(input host_bus_pkg::bus_mode_t m);
    is_68k = (m == host_bus_pkg::MODE_1) || (m == host_bus_pkg::MODE_2);
  endfunction : is_68k

  host_bus_pkg::bus_mode_t mode_reg;
  logic strap_done_reg;
  logic [7:0] dma_mode_reg;
  logic [7:0] dma_control_reg;
  logic [7:0] chip_test_zero_reg;
  logic [7:0] pin_ctrl_reg;
  logic start_reg, write_dir_reg, burst_reg, fetch_reg;
  logic ok_reg, fault_reg, retry_reg, burst_ok_reg, preview_reg;
  logic slave_write_reg, slave_bad_reg;
  logic [1:0] beat_reg;
  logic [2:0] slv_cnt_reg;
  mst_state_t mst_reg;
  slv_state_t slv_reg;
  logic test_mode, term, err, mst_on, apb_wr, apb_rd, cache_line, fam68k;
  logic [31:0] rd_data;
  logic rd_bad;

  assign test_mode = !conn_test_in_n;
  assign term = !sync_cycle_termination_n;
  assign err = !bus_fault_n_in;
  assign mst_on = (mst_reg == M_WAIT);
  assign fam68k = is_68k(mode_reg);
  assign cache_line = chip_test_zero_reg[host_bus_pkg::CACHE_LINE_MODE_BIT];
  // Writes land on the edge where the master samples pready
  assign apb_wr = psel && penable && pready && pwrite;
  assign apb_rd = psel && penable && !pready;

  // Straps are sampled once after reset release, never under the reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= host_bus_pkg::MODE_RESERVED;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      mode_reg <= decode_mode(bus_mode_select);
      strap_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_mode_reg <= host_bus_pkg::DMA_MODE_RST;
      dma_control_reg <= host_bus_pkg::DMA_CONTROL_RST;
      chip_test_zero_reg <= host_bus_pkg::CHIP_TEST_ZERO_RST;
      pin_ctrl_reg <= host_bus_pkg::PIN_CTRL_RST;
    end else if (apb_wr) begin
      unique case (paddr)
        host_bus_pkg::DMA_MODE_OFS: dma_mode_reg <= pwdata[7:0];
        host_bus_pkg::DMA_CONTROL_OFS: dma_control_reg <= pwdata[7:0];
        host_bus_pkg::CHIP_TEST_ZERO_OFS: chip_test_zero_reg <= pwdata[7:0];
        host_bus_pkg::PIN_CTRL_OFS: pin_ctrl_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_bad = 1'b0;
    unique case (paddr)
      host_bus_pkg::DMA_MODE_OFS: rd_data[7:0] = dma_mode_reg;
      host_bus_pkg::DMA_CONTROL_OFS: rd_data[7:0] = dma_control_reg;
      host_bus_pkg::CHIP_TEST_ZERO_OFS: rd_data[7:0] = chip_test_zero_reg;
      host_bus_pkg::PIN_CTRL_OFS: rd_data[7:0] = pin_ctrl_reg;
      host_bus_pkg::CYCLE_CMD_OFS:
        rd_data[3:0] = {fetch_reg, burst_reg, write_dir_reg, start_reg};
      host_bus_pkg::STATUS_OFS:
        rd_data[12:0] = {test_mode, slave_bad_reg, slave_write_reg,
                         (slv_reg != S_IDLE), preview_reg, burst_ok_reg,
                         retry_reg, fault_reg, ok_reg, mst_on, mode_reg};
      default: rd_bad = 1'b1;
    endcase
  end

  // One wait state so read data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_rd;
      prdata <= apb_rd ? rd_data : 32'h0000_0000;
      pslverr <= apb_rd && rd_bad;
    end
  end

  // Command bits; a new start during a cycle waits for idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg <= 1'b0;
      write_dir_reg <= 1'b0;
      burst_reg <= 1'b0;
      fetch_reg <= 1'b0;
    end else if (apb_wr && paddr == host_bus_pkg::CYCLE_CMD_OFS) begin
      start_reg <= pwdata[host_bus_pkg::CMD_START_BIT];
      write_dir_reg <= pwdata[host_bus_pkg::CMD_WRITE_BIT];
      burst_reg <= pwdata[host_bus_pkg::CMD_BURST_BIT];
      fetch_reg <= pwdata[host_bus_pkg::CMD_FETCH_BIT];
    end else if (mst_reg == M_IDLE && start_reg && !test_mode &&
                 mode_reg != host_bus_pkg::MODE_RESERVED) begin
      start_reg <= 1'b0;
    end else if (mst_on && term && !err) begin
      fetch_reg <= 1'b0;
    end
  end

  // Master cycle: wait for termination, retry or fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst_reg <= M_IDLE;
      beat_reg <= 2'h0;
      ok_reg <= 1'b0;
      fault_reg <= 1'b0;
      retry_reg <= 1'b0;
      burst_ok_reg <= 1'b0;
    end else begin
      unique case (mst_reg)
        M_IDLE: begin
          if (start_reg && !test_mode &&
              mode_reg != host_bus_pkg::MODE_RESERVED) begin
            mst_reg <= M_WAIT;
            beat_reg <= 2'h0;
            ok_reg <= 1'b0;
            fault_reg <= 1'b0;
            retry_reg <= 1'b0;
            burst_ok_reg <= 1'b0;
          end
        end
        M_WAIT: begin
          if (err && (mode_reg == host_bus_pkg::MODE_1 ? !halt_n : term)) begin
            retry_reg <= 1'b1;
            beat_reg <= 2'h0;
          end else if (err) begin
            fault_reg <= 1'b1;
            mst_reg <= M_IDLE;
          end else if (term) begin
            if (burst_reg && (mode_reg == host_bus_pkg::MODE_1 ?
                !line_burst_ack_n_in : line_burst_ack_n_in) &&
                beat_reg != host_bus_pkg::LINE_LAST_BEAT) begin
              beat_reg <= beat_reg + 2'h1;
              burst_ok_reg <= 1'b1;
            end else begin
              ok_reg <= 1'b1;
              mst_reg <= M_IDLE;
            end
          end
        end
        default: mst_reg <= M_IDLE;
      endcase
    end
  end

  // Slave cycle seen from the host side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slv_reg <= S_IDLE;
      slv_cnt_reg <= 3'h0;
      slave_write_reg <= 1'b0;
      slave_bad_reg <= 1'b0;
    end else begin
      unique case (slv_reg)
        S_IDLE: begin
          if (!chip_select_n && !slave_strobe_n && !test_mode && !mst_on) begin
            slv_reg <= S_BUSY;
            slv_cnt_reg <= 3'h0;
            slave_write_reg <= !read_write_in;
            slave_bad_reg <= slave_illegal;
          end
        end
        S_BUSY: begin
          slv_cnt_reg <= slv_cnt_reg + 3'h1;
          if (slv_cnt_reg == host_bus_pkg::SLAVE_DONE_CYC - 3'h1) begin
            slv_reg <= S_ACK;
          end
        end
        S_ACK: begin
          if (!fam68k) begin
            slv_reg <= S_HOLD;
          end else if (term || err) begin
            slv_reg <= S_IDLE;
          end
        end
        S_HOLD: begin
          if (!sync_cycle_termination_n) begin
            slv_reg <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Pin drivers; test mode floats them all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_write_out <= 1'b1;
      read_write_oe <= 1'b0;
      func_code_2_or_preview_out <= 1'b0;
      func_code_2_or_preview_oe <= 1'b0;
      func_code_low <= 2'h0;
      func_code_low_oe <= 1'b0;
      line_burst_request_n <= 1'b1;
      line_burst_request_oe <= 1'b0;
      preview_reg <= 1'b0;
    end else begin
      read_write_out <= !write_dir_reg;
      read_write_oe <= mst_on && !test_mode;
      // Pin becomes the address preview input when bit 6 is set
      func_code_2_or_preview_out <= dma_mode_reg[host_bus_pkg::FC2_BIT];
      func_code_2_or_preview_oe <= mst_on && !test_mode &&
        !dma_control_reg[host_bus_pkg::PREVIEW_MODE_BIT];
      preview_reg <= dma_control_reg[host_bus_pkg::PREVIEW_MODE_BIT] &&
        !func_code_2_or_preview_in;
      func_code_low[1] <= dma_mode_reg[host_bus_pkg::FC1_BIT] &&
        !dma_control_reg[host_bus_pkg::PREVIEW_MODE_BIT];
      func_code_low[0] <= dma_mode_reg[host_bus_pkg::PROG_DATA_BIT] &&
        fetch_reg;
      func_code_low_oe <= mst_on && !test_mode;
      // Mode 4 without cache-line mode keeps the pin as transfer type 1
      if (mode_reg == host_bus_pkg::MODE_1 ||
          (mode_reg == host_bus_pkg::MODE_4 && cache_line)) begin
        line_burst_request_n <= !burst_reg;
      end else begin
        line_burst_request_n <=
          !chip_test_zero_reg[host_bus_pkg::TYPE1_BIT];
      end
      line_burst_request_oe <= mst_on && !test_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snoop_level <= 2'h0;
      snoop_oe <= 1'b0;
      master_status_n <= 1'b1;
      master_status_oe <= 1'b0;
      opcode_fetch_n <= 1'b1;
      opcode_fetch_oe <= 1'b0;
      local_memory_select <= 1'b0;
      local_memory_oe <= 1'b0;
    end else begin
      snoop_level <= pin_ctrl_reg[host_bus_pkg::SNOOP_LSB +: 2];
      snoop_oe <= !test_mode && (mst_on ||
        pin_ctrl_reg[host_bus_pkg::SNOOP_PLAIN_BIT]);
      master_status_n <= !mst_on;
      master_status_oe <= !test_mode;
      opcode_fetch_n <= !fetch_reg;
      opcode_fetch_oe <= !test_mode;
      local_memory_select <= pin_ctrl_reg[host_bus_pkg::LOCAL_MEM_BIT];
      local_memory_oe <= !test_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_cycle_done_n <= 1'b1;
      slave_cycle_done_oe <= 1'b0;
      slave_data_oe <= 1'b0;
      bus_fault_n_out <= 1'b1;
      bus_fault_n_oe <= 1'b0;
      line_burst_ack_n_out <= 1'b1;
      line_burst_ack_n_oe <= 1'b0;
    end else begin
      // Same pin acknowledges in modes 1-2 and signals ready in 3-4
      slave_cycle_done_n <= !(slv_reg == S_ACK && !slave_bad_reg);
      slave_cycle_done_oe <= !test_mode;
      slave_data_oe <= !test_mode && !slave_write_reg &&
        (slv_reg == S_ACK || slv_reg == S_HOLD);
      bus_fault_n_out <= !(slv_reg == S_ACK && slave_bad_reg);
      bus_fault_n_oe <= !test_mode && slv_reg == S_ACK && slave_bad_reg;
      line_burst_ack_n_out <= (mode_reg == host_bus_pkg::MODE_1);
      line_burst_ack_n_oe <= !test_mode && !chip_select_n && !mst_on;
    end
  end

  // Board connectivity tree over every non-SCSI input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conn_test_out <= 1'b0;
      conn_test_out_oe <= 1'b0;
      pullup_en <= 1'b0;
    end else begin
      conn_test_out <= &{psel, penable, pwrite, paddr, pwdata,
        bus_mode_select, sync_cycle_termination_n, halt_n, chip_select_n,
        slave_strobe_n, slave_illegal, bus_fault_n_in, line_burst_ack_n_in,
        read_write_in, func_code_2_or_preview_in};
      conn_test_out_oe <= test_mode;
      pullup_en <= test_mode;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  strap_hold_a: assert property (strap_done_reg |=> $stable(mode_reg))
    else $error("mode changed after capture");
  reserved_a: assert property (!strap_done_reg &&
    bus_mode_select == host_bus_pkg::STRAP_RESERVED |=>
    mode_reg == host_bus_pkg::MODE_RESERVED)
    else $error("reserved strap not flagged");
  master_hold_a: assert property (mst_on && !term && !err |=> mst_on)
    else $error("master cycle ended without ready");
  term_done_a: assert property (mst_on && term && !err && !burst_reg
    |=> !mst_on ##0 ok_reg)
    else $error("termination did not end the cycle");
  retry_a: assert property (mst_on && err && term &&
    mode_reg != host_bus_pkg::MODE_1 |=> mst_on && retry_reg)
    else $error("error with ack did not retry");
  slave_ack_a: assert property (slv_reg == S_ACK && !slave_bad_reg
    |=> !slave_cycle_done_n || test_mode)
    else $error("slave acknowledge missing");
  slave_end_a: assert property (slv_reg == S_ACK && fam68k && !term && !err
    |=> slv_reg == S_ACK)
    else $error("slave cycle ended without termination");
  ready_out_a: assert property (slv_reg == S_ACK && !fam68k
    |=> slv_reg == S_HOLD && (!slave_cycle_done_n || slave_bad_reg)
    ##1 slave_cycle_done_n)
    else $error("ready output not a single pulse");
  master_low_a: assert property (mst_on && !test_mode
    |=> !master_status_n && master_status_oe)
    else $error("master status not low");
  burst_resp_a: assert property (!chip_select_n && !mst_on && !test_mode
    |=> line_burst_ack_n_oe &&
    line_burst_ack_n_out == (mode_reg == host_bus_pkg::MODE_1))
    else $error("slave burst response wrong");
  test_float_a: assert property (test_mode |=> conn_test_out_oe &&
    !master_status_oe && !read_write_oe && !snoop_oe)
    else $error("outputs not floated in test mode");
  fault_out_a: assert property (slv_reg == S_ACK && slave_bad_reg &&
    !test_mode |=> !bus_fault_n_out && bus_fault_n_oe)
    else $error("illegal access not faulted");
endmodule : host_bus_ctrl
`default_nettype wire

// ### sim/host_bus_partner.sv
`timescale 1ns/10ps
`default_nettype none
module host_bus_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic master_status_n,
  input wire logic slow,
  output logic term_n
);
  logic [2:0] cnt;
  logic done;
  // One answer per cycle; done stops a second ack while the cycle winds up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
      done <= 1'b0;
      term_n <= 1'b1;
    end else if (master_status_n) begin
      cnt <= 3'h0;
      done <= 1'b0;
      term_n <= 1'b1;
    end else if (!done && cnt == (slow ? 3'h4 : 3'h0)) begin
      done <= 1'b1;
      term_n <= 1'b0;
    end else begin
      cnt <= cnt + 3'h1;
      term_n <= 1'b1;
    end
  end
endmodule : host_bus_partner
`default_nettype wire

// ### sim/tb_multi_mode_host_bus_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_multi_mode_host_bus_control;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [2:0] bus_mode_select;
  logic sync_cycle_termination_n, halt_n, chip_select_n, slave_strobe_n;
  logic slave_illegal, conn_test_in_n, conn_test_out, conn_test_out_oe;
  logic pullup_en, bus_fault_n_in, bus_fault_n_out, bus_fault_n_oe;
  logic line_burst_ack_n_in, line_burst_ack_n_out, line_burst_ack_n_oe;
  logic read_write_in, read_write_out, read_write_oe;
  logic func_code_2_or_preview_in, func_code_2_or_preview_out;
  logic func_code_2_or_preview_oe, func_code_low_oe, line_burst_request_n;
  logic [1:0] func_code_low, snoop_level;
  logic line_burst_request_oe, snoop_oe, master_status_n, master_status_oe;
  logic opcode_fetch_n, opcode_fetch_oe, local_memory_select;
  logic local_memory_oe, slave_cycle_done_n, slave_cycle_done_oe;
  logic slave_data_oe, errv, rw_drv, term_drv_n, host_term_n, slow, flt_n;
  int n_mismatch = 0;
  int comparisons = 0;

  // Pulled-up pins read back their own drive when enabled
  assign bus_fault_n_in = bus_fault_n_oe ? bus_fault_n_out : flt_n;
  assign line_burst_ack_n_in =
    line_burst_ack_n_oe ? line_burst_ack_n_out : 1'b1;
  assign read_write_in = read_write_oe ? read_write_out : rw_drv;
  assign func_code_2_or_preview_in =
    func_code_2_or_preview_oe ? func_code_2_or_preview_out : 1'b1;
  assign sync_cycle_termination_n = host_term_n & term_drv_n;

  host_bus_ctrl DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bus_mode_select, .sync_cycle_termination_n, .halt_n,
    .chip_select_n, .slave_strobe_n, .slave_illegal, .conn_test_in_n,
    .conn_test_out, .conn_test_out_oe, .pullup_en, .bus_fault_n_in,
    .bus_fault_n_out, .bus_fault_n_oe, .line_burst_ack_n_in,
    .line_burst_ack_n_out, .line_burst_ack_n_oe, .read_write_in,
    .read_write_out, .read_write_oe, .func_code_2_or_preview_in,
    .func_code_2_or_preview_out, .func_code_2_or_preview_oe, .func_code_low,
    .func_code_low_oe, .line_burst_request_n, .line_burst_request_oe,
    .snoop_level, .snoop_oe, .master_status_n, .master_status_oe,
    .opcode_fetch_n, .opcode_fetch_oe, .local_memory_select,
    .local_memory_oe, .slave_cycle_done_n, .slave_cycle_done_oe,
    .slave_data_oe
  );
  host_bus_partner host (.pclk(pclk), .presetn(presetn),
    .master_status_n(master_status_n), .slow(slow), .term_n(host_term_n));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic end_sim;
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    check("pready", {31'h0, pready}, 32'h1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_for(input string what, ref logic sig, input logic v);
    int t;
    t = 0;
    while (sig !== v && t < 12) begin
      @(posedge pclk);
      t++;
    end
    check(what, sig, v);
  endtask : wait_for

  task automatic rst(input logic [2:0] s);
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    bus_mode_select <= s;
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : rst

  function automatic logic [2:0] mode_of(input int s);
    case (s)
      0, 2: return host_bus_pkg::MODE_4;
      1: return host_bus_pkg::MODE_3;
      3: return host_bus_pkg::MODE_RESERVED;
      4, 6: return host_bus_pkg::MODE_2;
      default: return host_bus_pkg::MODE_1;
    endcase
  endfunction : mode_of

  task automatic regs_and_straps;
    for (int s = 0; s < 8; s++) begin
      rst(s[2:0]);
      apb(1'b0, host_bus_pkg::STATUS_OFS, 32'h0);
      check("mode", {29'h0, rdv[2:0]}, {29'h0, mode_of(s)});
    end
    // Straps moved after reset must not reach the decoded mode
    bus_mode_select <= 3'h2;
    apb(1'b0, host_bus_pkg::STATUS_OFS, 32'h0);
    check("held mode", {29'h0, rdv[2:0]}, {29'h0, mode_of(7)});
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check("reset value", rdv, 32'h0);
    end
    apb(1'b1, 8'h40, 32'hFF);
    check("unmapped write", {31'h0, errv}, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped read", rdv, 32'h0);
    check("local default", {31'h0, local_memory_select}, 32'h0);
    apb(1'b1, host_bus_pkg::PIN_CTRL_OFS, 32'h8);
    wait_for("local select", local_memory_select, 1'b1);
  endtask : regs_and_straps

  task automatic master_cycle(input logic [2:0] s, input logic sl);
    int n;
    rst(s);
    slow <= sl;
    apb(1'b1, host_bus_pkg::PIN_CTRL_OFS, 32'h2);
    apb(1'b1, host_bus_pkg::DMA_MODE_OFS, 32'h10);
    apb(1'b1, host_bus_pkg::CHIP_TEST_ZERO_OFS, 32'h2);
    apb(1'b1, host_bus_pkg::CYCLE_CMD_OFS, 32'h8);
    wait_for("fetch", opcode_fetch_n, 1'b0);
    apb(1'b1, host_bus_pkg::CYCLE_CMD_OFS, 32'h3);
    if (s == host_bus_pkg::STRAP_RESERVED) begin
      repeat (10) @(posedge pclk);
      check("reserved idle", {31'h0, master_status_n}, 32'h1);
      return;
    end
    wait_for("master", master_status_n, 1'b0);
    check("direction", {30'h0, read_write_oe, read_write_out}, 32'h2);
    check("snoop", {29'h0, snoop_oe, snoop_level}, 32'h6);
    check("fc1", {31'h0, func_code_low[1]}, 32'h1);
    check("burst req", {30'h0, line_burst_request_oe,
      line_burst_request_n}, {30'h0, 1'b1, s[2] & s[0]});
    if (sl) begin
      {flt_n, halt_n, term_drv_n} <= 3'h0;
      @(posedge pclk);
      {flt_n, halt_n, term_drv_n} <= 3'h7;
    end
    n = 0;
    while (master_status_n === 1'b0 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    // Slow partner answers only after five cycles of waiting
    check("held", {31'h0, n >= (sl ? 5 : 1) && n < 20}, 32'h1);
    wait_for("snoop off", snoop_oe, 1'b0);
    apb(1'b0, host_bus_pkg::STATUS_OFS, 32'h0);
    check("ok", {30'h0, rdv[6], rdv[4]}, {30'h0, sl, 1'b1});
  endtask : master_cycle

  task automatic slave_cycle(input logic [2:0] s, input logic ill);
    rst(s);
    slave_illegal <= ill;
    chip_select_n <= 1'b0;
    slave_strobe_n <= 1'b0;
    wait_for("burst pin oe", line_burst_ack_n_oe, 1'b1);
    check("burst pin", {31'h0, line_burst_ack_n_out},
      {31'h0, s[0] & s[2]});
    if (ill) begin
      wait_for("fault", bus_fault_n_out, 1'b0);
      check("fault oe", {31'h0, bus_fault_n_oe}, 32'h1);
    end else begin
      wait_for("slave ack", slave_cycle_done_n, 1'b0);
      repeat (3) @(posedge pclk);
      if (s[2]) check("ack held", {31'h0, slave_cycle_done_n}, 32'h0);
      else begin
        check("ready pulse", {31'h0, slave_cycle_done_n}, 32'h1);
        check("data drive", {31'h0, slave_data_oe}, 32'h1);
      end
    end
    term_drv_n <= 1'b0;
    chip_select_n <= 1'b1;
    slave_strobe_n <= 1'b1;
    @(posedge pclk);
    term_drv_n <= 1'b1;
    wait_for("ack off", slave_cycle_done_n, 1'b1);
    wait_for("data off", slave_data_oe, 1'b0);
    slave_illegal <= 1'b0;
  endtask : slave_cycle

  task automatic test_mode;
    conn_test_in_n <= 1'b0;
    wait_for("tree oe", conn_test_out_oe, 1'b1);
    wait_for("pullups", pullup_en, 1'b1);
    check("status oe", {31'h0, master_status_oe}, 32'h0);
    {psel, penable, pwrite, slave_illegal} <= 4'hF;
    paddr <= 8'hFF;
    pwdata <= 32'hFFFF_FFFF;
    bus_mode_select <= 3'h7;
    wait_for("tree high", conn_test_out, 1'b1);
    psel <= 1'b0;
    wait_for("tree low", conn_test_out, 1'b0);
    {penable, pwrite, slave_illegal} <= 3'h0;
    conn_test_in_n <= 1'b1;
    wait_for("tree off", conn_test_out_oe, 1'b0);
    wait_for("status on", master_status_oe, 1'b1);
  endtask : test_mode

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    bus_mode_select = 3'h7;
    halt_n = 1'b1;
    chip_select_n = 1'b1;
    slave_strobe_n = 1'b1;
    slave_illegal = 1'b0;
    conn_test_in_n = 1'b1;
    rw_drv = 1'b1;
    term_drv_n = 1'b1;
    flt_n = 1'b1;
    slow = 1'b0;
    regs_and_straps();
    master_cycle(3'h7, 1'b1);
    master_cycle(3'h4, 1'b0);
    master_cycle(3'h1, 1'b1);
    master_cycle(3'h0, 1'b0);
    master_cycle(3'h3, 1'b0);
    slave_cycle(3'h7, 1'b0);
    slave_cycle(3'h6, 1'b0);
    slave_cycle(3'h1, 1'b0);
    slave_cycle(3'h2, 1'b0);
    slave_cycle(3'h4, 1'b1);
    test_mode();
    end_sim();
  end

  // Whole run is under a thousand cycles; this only catches a hang
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    end_sim();
  end
endmodule : tb_multi_mode_host_bus_control
`default_nettype wire
